/* File: hdl/mcuic_pkg.sv */
package mcuic_pkg;
    // Data addresses of the two control registers
    localparam logic [6:0] ADDR_CTRL0 = 7'h0B;
    localparam logic [6:0] ADDR_CTRL1 = 7'h1E;
    // Control register 0 field positions
    localparam int C0_MASTER_EN = 0;
    localparam int C0_EXT0_EN = 1;
    localparam int C0_EXT1_EN = 2;
    localparam int C0_TIMER_EN = 3;
    localparam int C0_EXT0_FLAG = 4;
    localparam int C0_EXT1_FLAG = 5;
    localparam int C0_TIMER_FLAG = 6;
    localparam int C0_TEST = 7;
    // Control register 1 field positions
    localparam int C1_TB_EN = 1;
    localparam int C1_RTC_EN = 2;
    localparam int C1_TB_FLAG = 5;
    localparam int C1_RTC_FLAG = 6;
    // Values after reset
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    // Vector addresses
    localparam logic [10:0] VEC_EXT0 = 11'h004;
    localparam logic [10:0] VEC_EXT1 = 11'h008;
    localparam logic [10:0] VEC_TIMER = 11'h00C;
    localparam logic [10:0] VEC_TB = 11'h014;
    localparam logic [10:0] VEC_RTC = 11'h018;
    // Source indices, in priority order
    localparam int NUM_SRC = 5;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 1;
    localparam int SRC_TIMER = 2;
    localparam int SRC_TB = 3;
    localparam int SRC_RTC = 4;
    // Edge option encodings
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
endpackage : mcuic_pkg

/* File: hdl/mcuic_top.sv */
// How it works
// RULE_01: Five sources: two external pins, timer, time base, real-time clock.
// RULE_02: Accepting any interrupt clears the master enable, blocking nesting.
// RULE_03: Requests with master enable clear still set their flags and wait.
// RULE_04: Software may re-enable master and source enables to nest handlers.
// RULE_05: No acknowledge while the return stack is full.
// RULE_06: Any of the five sources wakes the halted device.
// RULE_07: Acknowledge pushes only the program counter, then jumps to vector.
// RULE_08: Pin edges, chosen at build, set flags bit 4 and bit 5 of reg 0.
// RULE_09: External requests call 04H or 08H and clear flag and master.
// RULE_10: Timer overflow sets bit 6 of reg 0, calls 0CH, clears flags.
// RULE_11: Time base tick sets bit 5 of reg 1, calls 14H, clears flags.
// RULE_12: Clock tick sets bit 6 of reg 1, calls 18H, clears flags.
// RULE_13: Other acknowledges wait for return or both enables set again.
// RULE_14: Reg 0 enables: master bit 0, ext0 bit 1, ext1 bit 2, timer bit 3.
// RULE_15: Software must write zero to bit 7 of reg 0.
// RULE_16: Reg 0 at data address 0BH, reg 1 at 1EH.
// RULE_17: Priority: ext0, ext1, timer, time base, real-time clock.
// RULE_18: Return from interrupt sets master enable; plain return does not.
// RULE_19: Reg 1 enables time base bit 1, clock bit 2; bits 0, 3, 4 and 7 read zero.
// RULE_20: A set flag stays until serviced or cleared by software.
// RULE_21: Flags writable by software; a hardware set wins in same cycle.
`timescale 1ns/10ps
module mcuic_top #(
    parameter logic [1:0] EXT0_EDGE = mcuic_pkg::EDGE_FALL, // Pin 0 edge
    parameter logic [1:0] EXT1_EDGE = mcuic_pkg::EDGE_FALL  // Pin 1 edge
) (
    input wire logic clk, // System clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic ext_irq_pin_0, // External pin 0, asynchronous
    input wire logic ext_irq_pin_1, // External pin 1, asynchronous
    input wire logic timer_overflow, // Timer overflow pulse
    input wire logic timebase_tick, // Time base tick pulse
    input wire logic rtc_tick, // Real-time clock tick pulse
    input wire logic [6:0] reg_addr, // Data memory address
    input wire logic reg_wr, // Register write strobe
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data, registered
    input wire logic stack_full, // Return stack full
    input wire logic service_point, // Sequencer may take a vector now
    input wire logic return_from_interrupt, // Return that re-enables
    output logic irq_ack, // Acknowledge pulse: push PC, jump
    output logic [10:0] irq_vector, // Vector address, registered
    output logic wake_req // Wake the halted core
);
    logic [7:0] ctrl0_r;
    logic [7:0] ctrl1_r;
    logic [1:0] pin0_sync_r;
    logic [1:0] pin1_sync_r;
    logic pin0_prev_r;
    logic pin1_prev_r;
    logic ack_r;
    logic [10:0] vec_r;
    logic [7:0] rdata_r;
    logic [mcuic_pkg::NUM_SRC-1:0] flag_set;
    logic [mcuic_pkg::NUM_SRC-1:0] flags;
    logic [mcuic_pkg::NUM_SRC-1:0] enables;
    logic [mcuic_pkg::NUM_SRC-1:0] pending;
    logic [mcuic_pkg::NUM_SRC-1:0] grant;
    logic take;
    logic wr0;
    logic wr1;

    // Edge match under the build option
    function automatic logic edge_hit(input logic [1:0] mode,
                                      input logic prev, input logic cur);
        case (mode)
            mcuic_pkg::EDGE_FALL: edge_hit = prev & ~cur;
            mcuic_pkg::EDGE_RISE: edge_hit = ~prev & cur;
            default: edge_hit = prev ^ cur;
        endcase
    endfunction : edge_hit

    // Pins pass two flops before the edge detector sees them
    // Reset to the idle high level, so release shows no false edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin0_sync_r <= 2'h3;
            pin1_sync_r <= 2'h3;
            pin0_prev_r <= 1'b1;
            pin1_prev_r <= 1'b1;
        end else begin
            pin0_sync_r <= {pin0_sync_r[0], ext_irq_pin_0};
            pin1_sync_r <= {pin1_sync_r[0], ext_irq_pin_1};
            pin0_prev_r <= pin0_sync_r[1];
            pin1_prev_r <= pin1_sync_r[1];
        end
    end

    // Hardware set events, one per source
    assign flag_set[mcuic_pkg::SRC_EXT0] =
        edge_hit(EXT0_EDGE, pin0_prev_r, pin0_sync_r[1]); // RULE_08
    assign flag_set[mcuic_pkg::SRC_EXT1] =
        edge_hit(EXT1_EDGE, pin1_prev_r, pin1_sync_r[1]); // RULE_08
    assign flag_set[mcuic_pkg::SRC_TIMER] = timer_overflow; // RULE_10
    assign flag_set[mcuic_pkg::SRC_TB] = timebase_tick; // RULE_11
    assign flag_set[mcuic_pkg::SRC_RTC] = rtc_tick; // RULE_12

    // Gather flags and enables in priority order
    assign flags = {ctrl1_r[mcuic_pkg::C1_RTC_FLAG],
                    ctrl1_r[mcuic_pkg::C1_TB_FLAG],
                    ctrl0_r[mcuic_pkg::C0_TIMER_FLAG],
                    ctrl0_r[mcuic_pkg::C0_EXT1_FLAG],
                    ctrl0_r[mcuic_pkg::C0_EXT0_FLAG]}; // RULE_01
    assign enables = {ctrl1_r[mcuic_pkg::C1_RTC_EN],
                      ctrl1_r[mcuic_pkg::C1_TB_EN],
                      ctrl0_r[mcuic_pkg::C0_TIMER_EN],
                      ctrl0_r[mcuic_pkg::C0_EXT1_EN],
                      ctrl0_r[mcuic_pkg::C0_EXT0_EN]}; // RULE_14
    assign pending = flags & enables;

    // Master enable held clear during a handler stops all grants
    assign take = ctrl0_r[mcuic_pkg::C0_MASTER_EN] & ~stack_full
                  & service_point & (|pending); // RULE_05 RULE_13

    // Lowest index wins
    always_comb begin
        grant = '0;
        if (take) begin
            if (pending[0]) grant[0] = 1'b1; // RULE_17
            else if (pending[1]) grant[1] = 1'b1;
            else if (pending[2]) grant[2] = 1'b1;
            else if (pending[3]) grant[3] = 1'b1;
            else grant[4] = 1'b1;
        end
    end

    // Wake does not depend on enables, so any raised flag rouses the core
    assign wake_req = |flags; // RULE_06

    assign wr0 = reg_wr & (reg_addr == mcuic_pkg::ADDR_CTRL0); // RULE_16
    assign wr1 = reg_wr & (reg_addr == mcuic_pkg::ADDR_CTRL1); // RULE_16

    // Control register 0: write, then service clear, then hardware set
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl0_r <= mcuic_pkg::CTRL0_RESET;
        end else begin
            logic [7:0] v;
            v = ctrl0_r;
            if (wr0) begin
                v = reg_wdata; // RULE_21
            end
            // Test bit stored as written; software keeps it zero
            if (return_from_interrupt) begin
                v[mcuic_pkg::C0_MASTER_EN] = 1'b1; // RULE_18
            end
            if (take) begin
                v[mcuic_pkg::C0_MASTER_EN] = 1'b0; // RULE_02
            end
            if (grant[mcuic_pkg::SRC_EXT0]) v[mcuic_pkg::C0_EXT0_FLAG] = 1'b0;
            if (grant[mcuic_pkg::SRC_EXT1]) v[mcuic_pkg::C0_EXT1_FLAG] = 1'b0;
            if (grant[mcuic_pkg::SRC_TIMER]) begin
                v[mcuic_pkg::C0_TIMER_FLAG] = 1'b0; // RULE_09 RULE_10
            end
            // Set wins over any clear, so no event is lost
            if (flag_set[mcuic_pkg::SRC_EXT0]) begin
                v[mcuic_pkg::C0_EXT0_FLAG] = 1'b1; // RULE_03 RULE_20
            end
            if (flag_set[mcuic_pkg::SRC_EXT1]) begin
                v[mcuic_pkg::C0_EXT1_FLAG] = 1'b1; // RULE_21
            end
            if (flag_set[mcuic_pkg::SRC_TIMER]) begin
                v[mcuic_pkg::C0_TIMER_FLAG] = 1'b1;
            end
            ctrl0_r <= v;
        end
    end

    // Control register 1: only enables and flags are stored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl1_r <= mcuic_pkg::CTRL1_RESET;
        end else begin
            logic [7:0] v;
            v = ctrl1_r;
            if (wr1) begin
                v = 8'h00; // RULE_19
                v[mcuic_pkg::C1_TB_EN] = reg_wdata[mcuic_pkg::C1_TB_EN];
                v[mcuic_pkg::C1_RTC_EN] = reg_wdata[mcuic_pkg::C1_RTC_EN];
                v[mcuic_pkg::C1_TB_FLAG] = reg_wdata[mcuic_pkg::C1_TB_FLAG];
                v[mcuic_pkg::C1_RTC_FLAG] = reg_wdata[mcuic_pkg::C1_RTC_FLAG];
            end
            if (grant[mcuic_pkg::SRC_TB]) begin
                v[mcuic_pkg::C1_TB_FLAG] = 1'b0; // RULE_11
            end
            if (grant[mcuic_pkg::SRC_RTC]) begin
                v[mcuic_pkg::C1_RTC_FLAG] = 1'b0; // RULE_12
            end
            if (flag_set[mcuic_pkg::SRC_TB]) begin
                v[mcuic_pkg::C1_TB_FLAG] = 1'b1; // RULE_20
            end
            if (flag_set[mcuic_pkg::SRC_RTC]) begin
                v[mcuic_pkg::C1_RTC_FLAG] = 1'b1; // RULE_20
            end
            ctrl1_r <= v;
        end
    end

    // Acknowledge pulse with vector; sequencer pushes only the PC
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
            vec_r <= 11'h000;
        end else begin
            ack_r <= take; // RULE_07
            if (grant[0]) vec_r <= mcuic_pkg::VEC_EXT0; // RULE_09
            else if (grant[1]) vec_r <= mcuic_pkg::VEC_EXT1; // RULE_09
            else if (grant[2]) vec_r <= mcuic_pkg::VEC_TIMER; // RULE_10
            else if (grant[3]) vec_r <= mcuic_pkg::VEC_TB; // RULE_11
            else if (grant[4]) vec_r <= mcuic_pkg::VEC_RTC; // RULE_12
        end
    end

    // Registered read; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_r <= 8'h00;
        end else if (reg_addr == mcuic_pkg::ADDR_CTRL0) begin
            rdata_r <= ctrl0_r;
        end else if (reg_addr == mcuic_pkg::ADDR_CTRL1) begin
            rdata_r <= ctrl1_r;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign irq_ack = ack_r;
    assign irq_vector = vec_r;
    assign reg_rdata = rdata_r;
endmodule : mcuic_top

/* File: sim/mcuic_properties.sv */
`timescale 1ns/10ps
module mcuic_properties (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic timer_overflow, // Tick in
    input wire logic timebase_tick, // Tick in
    input wire logic rtc_tick, // Tick in
    input wire logic [6:0] reg_addr, // Address
    input wire logic reg_wr, // Write
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic stack_full, // Full
    input wire logic service_point, // May take
    input wire logic return_from_interrupt, // Return_from_interrupt
    input wire logic irq_ack, // Ack
    input wire logic [10:0] irq_vector, // Vector
    input wire logic wake_req // Wake
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Ack timing, cause and vector
    ack_single_a: assert property (irq_ack |=> !irq_ack)
        else $error("ack longer than one cycle");
    grant_cause_a: assert property (irq_ack |->
        $past(service_point && !stack_full)) else $error("bad grant");
    full_hold_a: assert property (stack_full |=> !irq_ack)
        else $error("ack while stack full");
    vec_legal_a: assert property (irq_ack |-> irq_vector inside
        {11'h004, 11'h008, 11'h00C, 11'h014, 11'h018}) else $error("vector");
    vec_hold_a: assert property (!irq_ack |-> $stable(irq_vector))
        else $error("vector moved");
    // Master cleared by grant blocks the next one
    no_nest_a: assert property (irq_ack && !reg_wr &&
        !return_from_interrupt |-> ##2 !irq_ack) else $error("nested ack");
    wake_src_a: assert property ((timer_overflow || timebase_tick ||
        rtc_tick) |=> wake_req) else $error("no wake");
    unmapped_a: assert property (!(reg_addr inside {7'h0B, 7'h1E})
        |=> reg_rdata == 8'h00) else $error("unmapped read");
    ctrl1_zero_a: assert property (reg_addr == 7'h1E
        |=> (reg_rdata & 8'h99) == 8'h00) else $error("ctrl1 spare");
    cover property (irq_ack && irq_vector == 11'h018);
    cover property (stack_full && wake_req);
    cover property (return_from_interrupt ##[1:9] irq_ack);
endmodule : mcuic_properties
bind mcuic_top mcuic_properties u_mcuic_properties (.clk, .rst_b,
    .timer_overflow, .timebase_tick, .rtc_tick, .reg_addr, .reg_wr,
    .reg_rdata, .stack_full, .service_point, .return_from_interrupt,
    .irq_ack, .irq_vector, .wake_req);

/* File: sim/mcuic_seq_model.sv */
`timescale 1ns/10ps
module mcuic_seq_model #(
    parameter int DEPTH = 6 // Stack levels
) (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic irq_ack, // Push request
    input wire logic [1:0] op, // 1 call, 2 ret, 3 return_from_interrupt
    output logic stack_full, // Stack full
    output logic service_point, // One cycle in four
    output logic return_from_interrupt // Return_from_interrupt pulse
);
    logic [2:0] depth_r;
    logic [1:0] phase_r;
    // Only the PC goes on the stack; returns pop one level
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            depth_r <= 3'h0;
        end else if (irq_ack || op == 2'h1) begin
            depth_r <= depth_r + 3'h1;
        end else if (op[1] && depth_r != 3'h0) begin
            depth_r <= depth_r - 3'h1;
        end
    end
    // Slow sequencer: takes vectors only at the end of a cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end
    assign service_point = (phase_r == 2'h3);
    assign stack_full = (depth_r == DEPTH[2:0]);
    assign return_from_interrupt = (op == 2'h3);
endmodule : mcuic_seq_model

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
    err_count++; $display("mismatch %s exp %h got %h", n, e, a); end end
module testbench;
    logic clk, rst_b, ext_irq_pin_0, ext_irq_pin_1, reg_wr, wake_req;
    logic timer_overflow, timebase_tick, rtc_tick, irq_ack, stack_full;
    logic service_point, return_from_interrupt;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [7:0] reg_rdata_edge;
    logic [10:0] irq_vector;
    logic [1:0] op;
    int err_count = 0, compares = 0, acks = 0, cycles = 0;
    logic [10:0] vecs [5] = '{11'h004, 11'h008, 11'h00C, 11'h014, 11'h018};
    mcuic_top u_mcuic_top (.clk, .rst_b, .ext_irq_pin_0, .ext_irq_pin_1,
        .timer_overflow, .timebase_tick, .rtc_tick, .reg_addr, .reg_wr,
        .reg_wdata, .reg_rdata, .stack_full, .service_point,
        .return_from_interrupt, .irq_ack, .irq_vector, .wake_req);
    // Second copy with the other pin edge options, same inputs
    mcuic_top #(.EXT0_EDGE(mcuic_pkg::EDGE_RISE),
        .EXT1_EDGE(mcuic_pkg::EDGE_BOTH)) u_mcuic_top_edge (.clk, .rst_b,
        .ext_irq_pin_0, .ext_irq_pin_1, .timer_overflow, .timebase_tick,
        .rtc_tick, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rdata(reg_rdata_edge), .stack_full, .service_point,
        .return_from_interrupt, .irq_ack(), .irq_vector(), .wake_req());
    mcuic_seq_model u_mcuic_seq_model (.clk, .rst_b, .irq_ack, .op,
        .stack_full, .service_point, .return_from_interrupt);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Ack count and hang guard
    always @(posedge clk) begin
        cycles++;
        if (irq_ack === 1'b1) acks++;
        if (cycles == 3000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 `CHK("reg_rdata", e, reg_rdata)
    endtask : rd
    task automatic wait_ack(input logic [10:0] e);
        int n = acks;
        for (int i = 0; i < 60 && acks == n; i++) begin
            @(posedge clk);
            #1;
        end
        // A stale vector must not pass for a missing acknowledge
        `CHK("ack seen", 1'b1, acks != n)
        `CHK("irq_vector", e, irq_vector)
    endtask : wait_ack
    task automatic quiet(input int c);
        int n = acks;
        repeat (c) @(posedge clk);
        #1 `CHK("ack count", n, acks)
    endtask : quiet
    task automatic t_pend();
        @(posedge clk);
        {ext_irq_pin_0, ext_irq_pin_1} <= 2'h0;
        {timer_overflow, timebase_tick, rtc_tick} <= 3'h7;
        @(posedge clk);
        {timer_overflow, timebase_tick, rtc_tick} <= 3'h0;
        quiet(8);
        rd(7'h0B, 8'h70);
        `CHK("edge reg_rdata", 8'h60, reg_rdata_edge)
        rd(7'h1E, 8'h60);
        `CHK("wake_req", 1'b1, wake_req)
        {ext_irq_pin_0, ext_irq_pin_1} <= 2'h3;
        repeat (4) @(posedge clk);
        rd(7'h0B, 8'h70);
        `CHK("edge reg_rdata", 8'h70, reg_rdata_edge)
    endtask : t_pend
    task automatic t_prio();
        wr(7'h1E, 8'h66);
        wr(7'h0B, 8'h7F);
        for (int i = 0; i < 5; i++) begin
            wait_ack(vecs[i]);
            quiet(8);
            op <= 2'h3;
            @(posedge clk);
            op <= 2'h0;
        end
        rd(7'h0B, 8'h0F);
        rd(7'h1E, 8'h06);
    endtask : t_prio
    task automatic t_full();
        op <= 2'h1;
        repeat (6) @(posedge clk);
        op <= 2'h0;
        timer_overflow <= 1'b1;
        @(posedge clk);
        timer_overflow <= 1'b0;
        quiet(12);
        rd(7'h0B, 8'h4F);
        op <= 2'h2;
        @(posedge clk);
        op <= 2'h0;
        wait_ack(11'h00C);
        rd(7'h0B, 8'h0E);
    endtask : t_full
    // Plain returns empty the stack; handler re-enables to nest
    task automatic t_nest();
        op <= 2'h2;
        repeat (6) @(posedge clk);
        op <= 2'h0;
        timer_overflow <= 1'b1;
        @(posedge clk);
        timer_overflow <= 1'b0;
        quiet(8);
        wr(7'h0B, 8'h4F);
        wait_ack(11'h00C);
        rd(7'h0B, 8'h0E);
        wr(7'h1E, 8'h26);
        rd(7'h1E, 8'h26);
        wr(7'h1E, 8'h06);
        rd(7'h1E, 8'h06);
    endtask : t_nest
    // Reset, then scenarios in order
    initial begin
        {rst_b, reg_wr, timer_overflow, timebase_tick, rtc_tick} = 5'h0;
        {ext_irq_pin_0, ext_irq_pin_1} = 2'h3;
        {reg_addr, reg_wdata, op} = 17'h0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(7'h0B, 8'h00);
        rd(7'h1E, 8'h00);
        rd(7'h0C, 8'h00);
        t_pend();
        t_prio();
        t_full();
        t_nest();
        end_sim();
    end
endmodule : testbench
